// file: dv/fpcc_chk_sva.sv
// Port checker for the console control block.
// Assumes one clock domain; bound onto fpcc_console.
`timescale 1ns/10ps
module fpcc_chk (
	input wire clock,
	input wire sys_rst,
	input wire clk_en,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire pready,
	input wire pslverr,
	input wire run_sw,
	input wire enable_slide,
	input wire entry_req,
	input wire cpu_byte_mode,
	input wire cpu_step,
	input wire cpu_run,
	input wire cpu_sense_true,
	input wire stop_lamp,
	input wire enable_lamp,
	input wire sense_lamp,
	input wire byte_lamp,
	input wire entry_grant
);
	reg [3:0] age_r;
	// Cycles since the run switch was last high or the command register last written
	always @(posedge clock)
		if (sys_rst || run_sw || (psel && pwrite && paddr == 8'h08))
			age_r <= 4'h0;
		else if (age_r != 4'hF)
			age_r <= age_r + 4'h1;
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	sequence s_on;
		(!sys_rst && enable_slide) [*4];
	endsequence
	sequence s_off;
		(!sys_rst && !enable_slide) [*4];
	endsequence
	a_enable_lamp: assert property (!$past(sys_rst) && !$past(sys_rst, 2)
		|-> enable_lamp == $past(enable_slide, 2)) else $error("enable lamp");
	a_byte_lamp: assert property (s_on ##0 $stable(cpu_byte_mode)
		##0 $past(cpu_byte_mode) == $past(cpu_byte_mode, 2) |-> byte_lamp == cpu_byte_mode)
		else $error("byte lamp");
	a_off_dark: assert property (s_off
		|-> !byte_lamp && !stop_lamp && !cpu_run && !entry_grant) else $error("disabled");
	a_step_once: assert property ($rose(cpu_step) |=> !cpu_step && !cpu_run)
		else $error("step pulse");
	a_run_press: assert property ($rose(cpu_run) |-> age_r < 4'h8)
		else $error("run start");
	a_stop_halts: assert property (stop_lamp && $past(stop_lamp, 3) |-> !cpu_run)
		else $error("stop lamp run");
	a_entry_gate: assert property (entry_grant |-> $past(entry_req) && !cpu_run)
		else $error("entry grant");
	a_sense_lamp: assert property ($changed(cpu_sense_true)
		|-> ##[1:3] sense_lamp == cpu_sense_true) else $error("sense lamp");
	a_bus_answer: assert property (psel && penable |-> pready == clk_en
		&& pslverr == !(paddr inside {8'h00, 8'h04, 8'h08})) else $error("bus answer");
endmodule
bind fpcc_console fpcc_chk u_chk (.clock, .sys_rst, .clk_en, .psel, .penable, .pwrite,
	.paddr, .pready, .pslverr, .run_sw, .enable_slide, .entry_req, .cpu_byte_mode,
	.cpu_step, .cpu_run, .cpu_sense_true, .stop_lamp, .enable_lamp, .sense_lamp,
	.byte_lamp, .entry_grant);

// file: dv/fpcc_console_tb.sv
// Self-checking bench for the console control block.
// Assumes zero-wait APB and the processor model as partner.
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
	$display("wrong value %s exp %h got %h", n, e, g); end end
module fpcc_console_tb;
	reg clock = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, en = 1, err;
	reg bm = 0, ov = 0, ereq = 0, sreq = 0, ireq = 0, ce = 1;
	reg [2:0] sw = 3'h0;
	reg [3:0] dly = 4'h5;
	reg [7:0] paddr = 8'h00;
	reg [31:0] pwdata = 32'h0, rd;
	wire [31:0] prdata;
	wire [7:0] steps;
	wire pready, pslverr, hlt, crun, cstep, sns, stop_l, run_l, en_l, sns_l, byte_l, ov_l, eg, sg, cg;
	integer num_errors = 0, samples_checked = 0, i;
	initial forever #2 clock = ~clock;
	fpcc_console u_dut (.clock(clock), .sys_rst(sys_rst), .clk_en(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .stop_sw(sw[0]), .run_sw(sw[1]), .sense_sw(sw[2]),
		.enable_slide(en), .entry_req(ereq), .sense_entry_req(sreq), .cint_req(ireq),
		.cpu_byte_mode(bm), .cpu_overflow(ov), .cpu_halted(hlt), .cpu_run(crun),
		.cpu_step(cstep), .cpu_sense_true(sns), .stop_lamp(stop_l), .run_lamp(run_l),
		.enable_lamp(en_l), .sense_lamp(sns_l), .byte_lamp(byte_l), .overflow_lamp(ov_l),
		.entry_grant(eg), .sense_entry_grant(sg), .cint_grant(cg));
	fpcc_cpu_model u_cpu (.clock(clock), .sys_rst(sys_rst), .dly(dly), .cpu_step(cstep),
		.cpu_run(crun), .cpu_halted(hlt), .steps_r(steps));
	// Print the counts and the verdict, then stop
	task summarize;
		begin
			$display("checked %0d errors %0d", samples_checked, num_errors);
			if (num_errors == 0 && samples_checked > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	// One APB transfer; read data and error taken at the ready edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		integer n;
		begin
			n = 0;
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge clock);
			penable <= 1'b1;
			@(posedge clock);
			while (pready !== 1'b1 && n < 20) begin
				n++;
				@(posedge clock);
			end
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			if (n == 20) begin
				num_errors++;
				summarize;
			end
			@(posedge clock);
		end
	endtask
	// One switch press, long enough for sync and the partner
	task press(input integer k);
		begin
			sw[k] <= 1'b1;
			repeat (6) @(posedge clock);
			sw[k] <= 1'b0;
			repeat (12) @(posedge clock);
		end
	endtask
	// Drive all three requests to e, then wait two cycles for the grants
	task req(input logic e);
		begin
			{ereq, sreq, ireq} <= {3{e}};
			repeat (2) @(posedge clock);
		end
	endtask
	initial begin
		repeat (6) @(posedge clock);
		sys_rst <= 1'b0;
		repeat (4) @(posedge clock);
		apb(1'b0, 8'h04, 32'h0);
		`CHK("stat", 32'h00000103, rd)
		`CHK("stop lamp", 1'b1, stop_l)
		press(1);
		press(1);
		`CHK("steps", 8'h02, steps)
		req(1'b1);
		`CHK("entry", 1'b1, eg)
		req(1'b0);
		$display("test step done");
		press(0);
		`CHK("stop lamp", 1'b0, stop_l)
		`CHK("armed", 1'b0, crun)
		press(1);
		`CHK("run", 1'b1, crun)
		`CHK("run lamp", 1'b1, run_l)
		req(1'b1);
		`CHK("entry", 1'b0, eg)
		req(1'b0);
		press(0);
		`CHK("halt", 1'b0, crun)
		`CHK("stop lamp", 1'b1, stop_l)
		$display("test run done");
		en <= 1'b0;
		bm <= 1'b1;
		press(2);
		press(0);
		press(1);
		`CHK("sense", 1'b1, sns)
		`CHK("sense lamp", 1'b1, sns_l)
		`CHK("en lamp", 1'b0, en_l)
		`CHK("byte off", 1'b0, byte_l)
		`CHK("no step", 8'h02, steps)
		apb(1'b0, 8'h00, 32'h0);
		`CHK("ctrl", 32'h00000003, rd)
		req(1'b1);
		`CHK("grants", 3'h3, {eg, sg, cg})
		req(1'b0);
		en <= 1'b1;
		$display("test disabled done");
		for (i = 0; i < 4; i++) begin
			{bm, ov} <= i[1:0];
			repeat (6) @(posedge clock);
			`CHK("lamps", i[1:0], {byte_l, ov_l})
		end
		`CHK("en lamp", 1'b1, en_l)
		apb(1'b1, 8'h00, 32'h0);
		apb(1'b1, 8'h08, 32'h4);
		apb(1'b0, 8'h08, 32'h0);
		`CHK("cmd", 32'h0, rd)
		apb(1'b1, 8'h0C, 32'h3);
		`CHK("unmapped", 1'b1, err)
		apb(1'b0, 8'h00, 32'h0);
		`CHK("ctrl", 32'h00000002, rd)
		$display("test bus done");
		// Frozen clock enable: no ready and a sense press is not seen
		ce <= 1'b0;
		sw[2] <= 1'b1;
		repeat (6) @(posedge clock);
		`CHK("frozen ready", 1'b0, pready)
		sw[2] <= 1'b0;
		repeat (2) @(posedge clock);
		ce <= 1'b1;
		repeat (8) @(posedge clock);
		`CHK("frozen sense", 1'b1, sns_l)
		$display("test freeze done");
		summarize;
	end
endmodule

// file: dv/fpcc_cpu_model.sv
// Behavioural processor run control facing the console.
// Assumes step and run requests on the system clock.
`timescale 1ns/10ps
module fpcc_cpu_model (
	input wire clock,
	input wire sys_rst,
	input wire [3:0] dly,
	input wire cpu_step,
	input wire cpu_run,
	output wire cpu_halted,
	output reg [7:0] steps_r
);
	reg [3:0] busy_r;
	// Count steps and stay busy dly cycles after each request
	always @(posedge clock)
		if (sys_rst) begin
			busy_r <= 4'h0;
			steps_r <= 8'h00;
		end else if (cpu_step || cpu_run) begin
			busy_r <= dly;
			steps_r <= steps_r + {7'h00, cpu_step};
		end else if (busy_r != 4'h0)
			busy_r <= busy_r - 4'h1;
	// Halted only when idle; a request drops it at once
	assign cpu_halted = busy_r == 4'h0 && !cpu_step && !cpu_run;
endmodule

// file: src/fpcc_apb.v
// APB slave for the console control block: decode, strobes and read data.
// Assumes a standard APB master; zero wait states while clk_en is high.
`timescale 1ns/10ps
`include "fpcc_defines.vh"
module fpcc_apb (
	input wire clock,
	input wire sys_rst,
	input wire clk_en,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire [31:0] ctrl_val,
	input wire [31:0] stat_val,
	output wire ctrl_wr,
	output wire cmd_wr,
	output wire [31:0] wr_data
);
	wire hit_ctrl;
	wire hit_stat;
	wire hit_cmd;
	wire mapped;
	wire access;

	// Address decode on aligned words only
	assign hit_ctrl = (paddr == `FPCC_CTRL_OFS);
	assign hit_stat = (paddr == `FPCC_STAT_OFS);
	assign hit_cmd = (paddr == `FPCC_CMD_OFS);
	assign mapped = hit_ctrl | hit_stat | hit_cmd;

	// Access completes on any enabled clock; frozen clock stretches it
	assign pready = clk_en;
	assign access = psel & penable & clk_en;
	assign pslverr = psel & penable & ~mapped;

	// Write strobes fire at the completing edge only
	assign ctrl_wr = access & pwrite & hit_ctrl;
	assign cmd_wr = access & pwrite & hit_cmd;
	assign wr_data = pwdata;

	// Read data captured in the setup cycle, held through the access
	always @(posedge clock) begin
		if (sys_rst) begin
			prdata <= 32'h00000000;
		end else if (clk_en && psel && !penable) begin
			if (pwrite || !mapped) begin
				prdata <= 32'h00000000;
			end else if (hit_ctrl) begin
				prdata <= ctrl_val;
			end else if (hit_stat) begin
				prdata <= stat_val;
			end else begin
				prdata <= 32'h00000000;
			end
		end
	end
endmodule

// file: src/fpcc_console.v
// Front-panel console control: mode toggles, stepping, sense and status lamps.
// Assumes a processor run-control partner that acknowledges each halt or step.
//
// Functional notes
// - Each stop press inverts the stop lamp, lit for Stop mode and dark for Run Enable mode.
// - In Stop mode with the console enabled, data entry and display are permitted.
// - In Stop mode each run press executes exactly one instruction and stops again.
// - In Run Enable mode all data entry and display operations are blocked.
// - Run Enable mode only arms running; continuous execution waits for a run press.
// - The enable lamp follows the enable slide switch.
// - With the console enabled every switch and indicator is active.
// - With the console disabled only sense, sense register entry and console interrupt stay live.
// - Each sense press inverts the sense lamp.
// - The program sense test is true exactly when the sense lamp is on; the code takes it from sense_r, which the lamp follows one enabled clock later.
// - The byte lamp is lit in byte mode and dark in word mode.
// - The overflow lamp mirrors the processor overflow flag.
// - Console state is volatile, reset to Stop mode with sense off and restorable by software.
// - With the stop lamp dark a run press moves the machine from Run Enable into Run.
`timescale 1ns/10ps
`include "fpcc_defines.vh"
module fpcc_console (
	input wire clock,
	input wire sys_rst,
	input wire clk_en,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire stop_sw,
	input wire run_sw,
	input wire sense_sw,
	input wire enable_slide,
	input wire entry_req,
	input wire sense_entry_req,
	input wire cint_req,
	input wire cpu_byte_mode,
	input wire cpu_overflow,
	input wire cpu_halted,
	output wire cpu_run,
	output reg cpu_step,
	output wire cpu_sense_true,
	output reg stop_lamp,
	output reg run_lamp,
	output reg enable_lamp,
	output reg sense_lamp,
	output reg byte_lamp,
	output reg overflow_lamp,
	output reg entry_grant,
	output reg sense_entry_grant,
	output reg cint_grant
);
	// Run-control states, one-hot
	localparam [3:0] ST_IDLE = 4'h1;
	localparam [3:0] ST_STEP = 4'h2;
	localparam [3:0] ST_RUN = 4'h4;
	localparam [3:0] ST_HALT = 4'h8;

	wire stop_press;
	wire run_press;
	wire sense_press;
	wire ctrl_wr;
	wire cmd_wr;
	wire [31:0] wr_data;
	wire [31:0] ctrl_val;
	wire [31:0] stat_val;

	reg stop_r;
	reg stop_nxt;
	reg sense_r;
	reg sense_nxt;
	reg enable_r;
	reg [3:0] state_r;
	reg [3:0] state_nxt;
	reg step_nxt;

	wire stop_evt;
	wire run_evt;
	wire sense_evt;
	wire entry_ok;

	// Press detectors for the three momentary switches
	fpcc_sw_edge u_stop_edge (
		.clock(clock),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.sw_in(stop_sw),
		.press(stop_press)
	);

	fpcc_sw_edge u_run_edge (
		.clock(clock),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.sw_in(run_sw),
		.press(run_press)
	);

	fpcc_sw_edge u_sense_edge (
		.clock(clock),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.sw_in(sense_sw),
		.press(sense_press)
	);

	// Register bus slave
	fpcc_apb u_apb (
		.clock(clock),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.ctrl_val(ctrl_val),
		.stat_val(stat_val),
		.ctrl_wr(ctrl_wr),
		.cmd_wr(cmd_wr),
		.wr_data(wr_data)
	);

	// Enable slide switch sampled once per enabled clock
	always @(posedge clock) begin
		if (sys_rst) begin
			enable_r <= 1'b0;
		end else if (clk_en) begin
			enable_r <= enable_slide;
		end
	end

	// Stop and run only count while the console is enabled; sense always counts
	assign stop_evt = enable_r & (stop_press | (cmd_wr & wr_data[`FPCC_CMD_STOP_BIT]));
	assign run_evt = enable_r & (run_press | (cmd_wr & wr_data[`FPCC_CMD_RUN_BIT]));
	assign sense_evt = sense_press | (cmd_wr & wr_data[`FPCC_CMD_SENSE_BIT]);

	// Toggle lamps: a software restore is taken first, a press on top of it still toggles
	always @* begin
		stop_nxt = stop_r;
		sense_nxt = sense_r;
		if (ctrl_wr) begin
			stop_nxt = wr_data[`FPCC_CTRL_STOP_BIT];
			sense_nxt = wr_data[`FPCC_CTRL_SENSE_BIT];
		end
		if (stop_evt) begin
			stop_nxt = ~stop_nxt;
		end
		if (sense_evt) begin
			sense_nxt = ~sense_nxt;
		end
	end

	// Volatile console state, set to Stop mode with sense off by reset
	always @(posedge clock) begin
		if (sys_rst) begin
			stop_r <= `FPCC_STOP_RST;
			sense_r <= `FPCC_SENSE_RST;
		end else if (clk_en) begin
			stop_r <= stop_nxt;
			sense_r <= sense_nxt;
		end
	end

	// Run control: single step in Stop mode, continuous run from Run Enable
	always @* begin
		state_nxt = state_r;
		step_nxt = 1'b0;
		case (state_r)
			ST_IDLE: begin
				if (run_evt && stop_r) begin
					state_nxt = ST_STEP;
					step_nxt = 1'b1;
				end else if (run_evt && !stop_r) begin
					state_nxt = ST_RUN;
				end
			end
			ST_STEP: begin
				if (cpu_halted) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_RUN: begin
				if (stop_r || !enable_r) begin
					state_nxt = ST_HALT;
				end
			end
			ST_HALT: begin
				if (cpu_halted) begin
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// State register and one-cycle step request
	always @(posedge clock) begin
		if (sys_rst) begin
			state_r <= ST_IDLE;
			cpu_step <= 1'b0;
		end else if (clk_en) begin
			state_r <= state_nxt;
			cpu_step <= step_nxt;
		end
	end

	// Continuous execution only in the run state
	assign cpu_run = (state_r == ST_RUN);

	// Sense test answer comes straight from the toggle flop sense_r, one enabled clock ahead of the lamp flop
	assign cpu_sense_true = sense_r;

	// Data entry allowed only when stopped, idle and enabled
	assign entry_ok = enable_r & stop_r & (state_r == ST_IDLE);

	// Front-panel lamps and request gates
	always @(posedge clock) begin
		if (sys_rst) begin
			stop_lamp <= 1'b0;
			run_lamp <= 1'b0;
			enable_lamp <= 1'b0;
			sense_lamp <= 1'b0;
			byte_lamp <= 1'b0;
			overflow_lamp <= 1'b0;
			entry_grant <= 1'b0;
			sense_entry_grant <= 1'b0;
			cint_grant <= 1'b0;
		end else if (clk_en) begin
			enable_lamp <= enable_r;
			stop_lamp <= enable_r & stop_r;
			run_lamp <= enable_r & (state_r == ST_RUN);
			sense_lamp <= sense_r;
			byte_lamp <= enable_r & cpu_byte_mode;
			overflow_lamp <= enable_r & cpu_overflow;
			entry_grant <= entry_req & entry_ok;
			sense_entry_grant <= sense_entry_req;
			cint_grant <= cint_req & (state_r == ST_RUN | ~enable_r);
		end
	end

	// Register read values
	assign ctrl_val = {30'h00000000, sense_r, stop_r};
	assign stat_val = {23'h000000, entry_ok, state_r[3], state_r[1], state_r[2],
		overflow_lamp, byte_lamp, sense_r, stop_r, enable_r};
endmodule

// file: src/fpcc_defines.vh
// Constants for the front-panel console control block.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef FPCC_DEFINES_VH
`define FPCC_DEFINES_VH

// APB register byte offsets
`define FPCC_CTRL_OFS 8'h00
`define FPCC_STAT_OFS 8'h04
`define FPCC_CMD_OFS 8'h08

// Control register fields (read/write, restores toggle lamps)
`define FPCC_CTRL_STOP_BIT 0
`define FPCC_CTRL_SENSE_BIT 1

// Command register fields (write-only pulses, read as zero)
`define FPCC_CMD_STOP_BIT 0
`define FPCC_CMD_RUN_BIT 1
`define FPCC_CMD_SENSE_BIT 2

// Status register fields (read-only)
`define FPCC_STAT_ENABLE_BIT 0
`define FPCC_STAT_STOP_BIT 1
`define FPCC_STAT_SENSE_BIT 2
`define FPCC_STAT_BYTE_BIT 3
`define FPCC_STAT_OVF_BIT 4
`define FPCC_STAT_RUN_BIT 5
`define FPCC_STAT_STEP_BIT 6
`define FPCC_STAT_HALT_BIT 7
`define FPCC_STAT_ENTRY_BIT 8

// Reset values of the volatile console state
`define FPCC_STOP_RST 1'b1
`define FPCC_SENSE_RST 1'b0

`endif

// file: src/fpcc_sw_edge.v
// Synchroniser and press detector for one momentary console switch.
// Assumes the switch level is already debounced; one press is one rising edge.
`timescale 1ns/10ps
module fpcc_sw_edge (
	input wire clock,
	input wire sys_rst,
	input wire clk_en,
	input wire sw_in,
	output wire press
);
	reg meta_r;
	reg sync_r;
	reg last_r;

	// Two-stage synchroniser followed by a history flop
	always @(posedge clock) begin
		if (sys_rst) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			last_r <= 1'b0;
		end else if (clk_en) begin
			meta_r <= sw_in;
			sync_r <= meta_r;
			last_r <= sync_r;
		end
	end

	// One pulse per rising edge of the synchronised level
	assign press = clk_en & sync_r & ~last_r;
endmodule
